// file: rtl/mbt_pkg.sv
// Shared constants and types of the request server
package mbt_pkg;

  // Function codes handled by the server
  localparam logic [7:0] FC_RD_RELAY = 8'h01;
  localparam logic [7:0] FC_RD_DIN = 8'h02;
  localparam logic [7:0] FC_RD_REGS = 8'h03;
  localparam logic [7:0] FC_WR_RELAY = 8'h05;
  localparam logic [7:0] FC_WR_REGS = 8'h10;

  // Application header
  localparam logic [8:0] HDR_LEN = 9'h007;
  localparam logic [15:0] PROTO_MODBUS = 16'h0000;
  localparam logic [7:0] UNIT_MAX = 8'hf7;
  // Bytes that precede the unit identifier and so are not counted by the length field
  localparam logic [15:0] LEN_PRE = 16'h0006;

  // Byte positions inside a request or response
  localparam int IDX_W = 9;
  localparam logic [8:0] OFS_TID = 9'h000;
  localparam logic [8:0] OFS_PROTO = 9'h002;
  localparam logic [8:0] OFS_LEN = 9'h004;
  localparam logic [8:0] OFS_UNIT = 9'h006;
  localparam logic [8:0] OFS_FC = 9'h007;
  localparam logic [8:0] OFS_ADDR = 9'h008;
  localparam logic [8:0] OFS_QTY = 9'h00a;
  localparam logic [8:0] OFS_BCNT = 9'h00c;
  localparam logic [8:0] OFS_WDATA = 9'h00d;
  localparam logic [8:0] OFS_RSP_DATA = 9'h009;
  localparam int MAX_FRAME = 260;

  // Length values of fixed-size frames, and the fixed part of a read reply's length
  localparam logic [15:0] REQ_FIXED_LEN = 16'h0006;
  localparam logic [15:0] RSP_FIXED_LEN = 16'h0006;
  localparam logic [15:0] RSP_DATA_PRE = 16'h0003;

  // Bit-addressed objects
  localparam logic [16:0] RELAY_COUNT = 17'h00008;
  localparam logic [16:0] DIN_COUNT = 17'h00026;
  localparam logic [15:0] RELAY_BASE = 16'h0000;
  localparam logic [15:0] DIN_BASE = 16'h0000;
  localparam logic [15:0] RELAY_ON_VAL = 16'hff00;
  localparam logic [15:0] RELAY_OFF_VAL = 16'h0000;
  localparam logic [7:0] RELAY_RESET = 8'h00;

  // Register transfer limits
  localparam logic [15:0] MAX_RD_REGS = 16'h007d;
  localparam logic [15:0] MAX_WR_REGS = 16'h007b;

  // Clock-time registers
  localparam logic [15:0] RTC_BASE = 16'h1040;
  localparam logic [15:0] RTC_REGS = 16'h0006;
  localparam int RTC_YEAR = 0;
  localparam int RTC_MONTH = 1;
  localparam int RTC_DAY = 2;
  localparam int RTC_HOUR = 3;
  localparam int RTC_MIN = 4;
  localparam int RTC_SEC = 5;
  localparam logic [15:0] RTC_YEAR_RESET = 16'h07d0;
  localparam logic [15:0] RTC_MONTH_RESET = 16'h0001;
  localparam logic [15:0] RTC_DAY_RESET = 16'h0001;

  // One-second time base
  localparam int CLK_HZ = 10_000_000;
  localparam int RTC_TICK_MS = 1000;
  localparam int RTC_TICK_CYCLES = CLK_HZ / 1000 * RTC_TICK_MS;

  typedef enum logic [1:0] {ST_RX, ST_CHECK, ST_WRITE, ST_SEND} mbt_state_t;

endpackage : mbt_pkg

// file: rtl/mbt_frame_store.sv
// Byte store for one received request, read back as 16-bit words
`timescale 1ns/10ps
module mbt_frame_store #(
  parameter int DEPTH = mbt_pkg::MAX_FRAME
) (
  input wire logic clk, // System clock
  input wire logic wr_en, // Store one byte
  input wire logic [mbt_pkg::IDX_W-1:0] wr_idx, // Byte position
  input wire logic [7:0] wr_data, // Byte value
  input wire logic [mbt_pkg::IDX_W-1:0] rd_idx, // Position of high byte
  output logic [15:0] rd_word // High byte then low byte
);

  logic [7:0] mem [DEPTH];
  wire [mbt_pkg::IDX_W-1:0] rd_idx_lo = rd_idx + 9'h001;
  wire hi_in = 32'(rd_idx) < DEPTH;
  wire lo_in = 32'(rd_idx_lo) < DEPTH;

  // Contents need no reset: only bytes of the current frame are ever read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  assign rd_word = {hi_in ? mem[rd_idx] : 8'h00, lo_in ? mem[rd_idx_lo] : 8'h00};

endmodule : mbt_frame_store

// file: rtl/mbt_rtc_regs.sv
// Clock-time holding registers with a one-second calendar
`timescale 1ns/10ps
module mbt_rtc_regs #(
  parameter int TICK_CYCLES = mbt_pkg::RTC_TICK_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic wr_en, // Write one register
  input wire logic [15:0] wr_addr, // Register address to write
  input wire logic [15:0] wr_data, // Value to write
  input wire logic [15:0] rd_addr, // Register address to read
  output logic [15:0] rd_data // Value read, zero when unmapped
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [15:0] tm_q [6];
  logic [TW-1:0] div_q;

  function automatic logic [15:0] days_in_month(input logic [15:0] year, input logic [15:0] month);
    if (month == 16'h0002) begin
      days_in_month = (year[1:0] == 2'b00) ? 16'h001d : 16'h001c;
    end else if (month == 16'h0004 || month == 16'h0006 || month == 16'h0009 || month == 16'h000b) begin
      days_in_month = 16'h001e;
    end else begin
      days_in_month = 16'h001f;
    end
  endfunction : days_in_month

  wire [15:0] rd_ofs = rd_addr - mbt_pkg::RTC_BASE;
  wire [15:0] wr_ofs = wr_addr - mbt_pkg::RTC_BASE;
  wire rd_hit = (rd_addr >= mbt_pkg::RTC_BASE) && (rd_ofs < mbt_pkg::RTC_REGS);
  wire wr_hit = wr_en && (wr_addr >= mbt_pkg::RTC_BASE) && (wr_ofs < mbt_pkg::RTC_REGS);
  wire tick = (div_q == TW'(TICK_CYCLES - 1));
  wire sec_wrap = tm_q[mbt_pkg::RTC_SEC] >= 16'h003b;
  wire min_wrap = sec_wrap && tm_q[mbt_pkg::RTC_MIN] >= 16'h003b;
  wire hour_wrap = min_wrap && tm_q[mbt_pkg::RTC_HOUR] >= 16'h0017;
  wire day_wrap = hour_wrap &&
    tm_q[mbt_pkg::RTC_DAY] >= days_in_month(tm_q[mbt_pkg::RTC_YEAR], tm_q[mbt_pkg::RTC_MONTH]);
  wire month_wrap = day_wrap && tm_q[mbt_pkg::RTC_MONTH] >= 16'h000c;

  assign rd_data = rd_hit ? tm_q[rd_ofs[2:0]] : 16'h0000;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + TW'(1);
    end
  end

  // A host write wins over the calendar step of the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tm_q[mbt_pkg::RTC_YEAR] <= mbt_pkg::RTC_YEAR_RESET;
      tm_q[mbt_pkg::RTC_MONTH] <= mbt_pkg::RTC_MONTH_RESET;
      tm_q[mbt_pkg::RTC_DAY] <= mbt_pkg::RTC_DAY_RESET;
      tm_q[mbt_pkg::RTC_HOUR] <= 16'h0000;
      tm_q[mbt_pkg::RTC_MIN] <= 16'h0000;
      tm_q[mbt_pkg::RTC_SEC] <= 16'h0000;
    end else if (wr_hit) begin
      tm_q[wr_ofs[2:0]] <= wr_data;
    end else if (tick) begin
      tm_q[mbt_pkg::RTC_SEC] <= sec_wrap ? 16'h0000 : tm_q[mbt_pkg::RTC_SEC] + 16'h0001;
      if (sec_wrap) begin
        tm_q[mbt_pkg::RTC_MIN] <= min_wrap ? 16'h0000 : tm_q[mbt_pkg::RTC_MIN] + 16'h0001;
      end
      if (min_wrap) begin
        tm_q[mbt_pkg::RTC_HOUR] <= hour_wrap ? 16'h0000 : tm_q[mbt_pkg::RTC_HOUR] + 16'h0001;
      end
      if (hour_wrap) begin
        tm_q[mbt_pkg::RTC_DAY] <= day_wrap ? 16'h0001 : tm_q[mbt_pkg::RTC_DAY] + 16'h0001;
      end
      if (day_wrap) begin
        tm_q[mbt_pkg::RTC_MONTH] <= month_wrap ? 16'h0001 : tm_q[mbt_pkg::RTC_MONTH] + 16'h0001;
      end
      if (month_wrap) begin
        tm_q[mbt_pkg::RTC_YEAR] <= tm_q[mbt_pkg::RTC_YEAR] + 16'h0001;
      end
    end
  end

endmodule : mbt_rtc_regs

// file: rtl/mbt_request_server.sv
// Request parser and response builder of the Modbus-TCP server
`timescale 1ns/10ps
//
// Behaviour
// - Every frame opens with a seven-byte application header.
// - Transaction identifier tags a request/response pair and returns unchanged.
// - Protocol identifier is two bytes, high first, and must be zero.
// - Length counts the bytes after it; it delimits requests and is computed for replies.
// - Unit identifier is the last header byte, range 0 to 247.
// - One function-code byte after the header selects the action.
// - Codes 01, 02 and 03 read relays, discrete inputs and registers.
// - Code 05 forces one relay; code 16 writes consecutive registers.
// - Every data-field element is one byte, 00 to FF.
// - Register read carries start address then register count.
// - Register write carries start, count, byte count, then values.
// - All two-byte fields travel high byte first.
// - Eight relays from address zero; status bit 1 means on.
// - Relay reply holds header, code, byte count, bits; first relay in bit0.
// - Thirty-eight discrete inputs from address zero.
// - Input reply holds header, code, byte count, bits; first input in bit0.
// - Register reply holds code, byte count twice the count, values high then low.
// - Six clock-time registers from 1040H: year, month, day, hour, minute, second.
// - FF00H turns a relay on, 0000H off, anything else changes nothing.
// - Relay force reply echoes the request after the relay has changed.
// - Register write reply holds header, code, start and count only.
module mbt_request_server #(
  parameter int MAX_FRAME = mbt_pkg::MAX_FRAME,
  parameter int TICK_CYCLES = mbt_pkg::RTC_TICK_CYCLES
) (
  input wire logic clk, // System clock, 10 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic rx_valid, // Request byte present
  input wire logic [7:0] rx_data, // Request byte
  input wire logic rx_last, // Last byte of the request
  output logic rx_ready, // Server takes a request byte
  output logic tx_valid, // Response byte present
  output logic [7:0] tx_data, // Response byte
  output logic tx_last, // Last byte of the response
  input wire logic tx_ready, // Client side takes a response byte
  input wire logic [37:0] discrete_input_line, // Discrete input levels
  output logic [7:0] relay_out // Relay states, 1 is on
);

  localparam int W = mbt_pkg::IDX_W;

  mbt_pkg::mbt_state_t state_q;
  logic [W-1:0] rx_cnt_q;
  logic rx_ovf_q;
  logic [15:0] tid_q;
  logic [15:0] proto_q;
  logic [15:0] len_q;
  logic [7:0] unit_q;
  logic [7:0] fc_q;
  logic [15:0] addr_q;
  logic [15:0] qty_q;
  logic [7:0] bcnt_q;
  logic [7:0] relay_q;
  logic [6:0] wr_i_q;
  logic [W-1:0] tx_idx_q;
  logic [7:0] tx_data_q;
  logic tx_valid_q;
  logic tx_last_q;
  logic [7:0] rsp_byte;

  // Start plus count must stay inside the object range, and the count is at least one
  function automatic logic span_fits(input logic [15:0] start, input logic [15:0] cnt, input logic [16:0] lim);
    span_fits = (cnt != 16'h0000) && (({1'b0, start} + {1'b0, cnt}) <= lim);
  endfunction : span_fits

  function automatic logic [7:0] hi_byte(input logic [15:0] v);
    hi_byte = v[15:8];
  endfunction : hi_byte

  function automatic logic [7:0] lo_byte(input logic [15:0] v);
    lo_byte = v[7:0];
  endfunction : lo_byte

  // Receive side
  wire rx_fire = rx_valid && rx_ready;
  wire in_rx = (state_q == mbt_pkg::ST_RX);
  wire in_check = (state_q == mbt_pkg::ST_CHECK);
  wire in_write = (state_q == mbt_pkg::ST_WRITE);
  wire in_send = (state_q == mbt_pkg::ST_SEND);
  wire rx_full = (32'(rx_cnt_q) >= MAX_FRAME);
  wire store_wr = rx_fire && !rx_full;

  // Request screening
  wire [15:0] rx_seen_len = {{(16 - W){1'b0}}, rx_cnt_q} - mbt_pkg::LEN_PRE;
  wire is_rd_relay = (fc_q == mbt_pkg::FC_RD_RELAY);
  wire is_rd_din = (fc_q == mbt_pkg::FC_RD_DIN);
  wire is_rd_regs = (fc_q == mbt_pkg::FC_RD_REGS);
  wire is_wr_relay = (fc_q == mbt_pkg::FC_WR_RELAY);
  wire is_wr_regs = (fc_q == mbt_pkg::FC_WR_REGS);
  wire fixed_len = (len_q == mbt_pkg::REQ_FIXED_LEN);
  wire hdr_full = (rx_cnt_q > mbt_pkg::HDR_LEN) && !rx_ovf_q;
  wire proto_ok = (proto_q == mbt_pkg::PROTO_MODBUS);
  wire len_ok = (len_q == rx_seen_len);
  wire unit_ok = (unit_q <= mbt_pkg::UNIT_MAX);
  wire rd_relay_ok = is_rd_relay && fixed_len &&
    span_fits(addr_q - mbt_pkg::RELAY_BASE, qty_q, mbt_pkg::RELAY_COUNT);
  wire rd_din_ok = is_rd_din && fixed_len &&
    span_fits(addr_q - mbt_pkg::DIN_BASE, qty_q, mbt_pkg::DIN_COUNT);
  // count of a register read, 1 to 125; the start address is not checked
  wire rd_regs_ok = is_rd_regs && fixed_len && (qty_q != 16'h0000) && (qty_q <= mbt_pkg::MAX_RD_REGS);
  wire wr_relay_ok = is_wr_relay && fixed_len &&
    ({1'b0, addr_q - mbt_pkg::RELAY_BASE} < mbt_pkg::RELAY_COUNT);
  // byte count matches count and length
  wire wr_regs_ok = is_wr_regs && (qty_q != 16'h0000) && (qty_q <= mbt_pkg::MAX_WR_REGS) &&
    ({8'h00, bcnt_q} == {qty_q[14:0], 1'b0}) &&
    (len_q == mbt_pkg::REQ_FIXED_LEN + 16'h0001 + {8'h00, bcnt_q});
  wire fc_ok = rd_relay_ok || rd_din_ok || rd_regs_ok || wr_relay_ok || wr_regs_ok;
  wire req_ok = hdr_full && proto_ok && len_ok && unit_ok && fc_ok;

  // Response sizing
  wire [7:0] bit_bytes = 8'(({1'b0, qty_q} + 17'h00007) >> 3);
  wire [7:0] reg_bytes = {qty_q[6:0], 1'b0};
  wire [7:0] rsp_nbytes = is_rd_regs ? reg_bytes : bit_bytes;
  wire [15:0] rsp_len = (is_wr_relay || is_wr_regs) ? mbt_pkg::RSP_FIXED_LEN :
    mbt_pkg::RSP_DATA_PRE + {8'h00, rsp_nbytes};
  wire [W-1:0] rsp_total = W'(rsp_len + mbt_pkg::LEN_PRE);

  // Index of the byte to load into the output register next
  wire [W-1:0] ld_idx = in_send ? tx_idx_q + 9'h001 : 9'h000;
  wire [W-1:0] body_idx = ld_idx - mbt_pkg::OFS_RSP_DATA;
  wire ld_last = (ld_idx == rsp_total - 9'h001);

  // Status bits, first requested object at bit0
  wire [39:0] bit_src = is_rd_relay ? {32'h0000_0000, relay_q} : {2'b00, discrete_input_line};
  wire [39:0] bit_mask = ~(40'hff_ffff_ffff << qty_q[5:0]);
  wire [39:0] bit_field = (bit_src >> addr_q[5:0]) & bit_mask;
  wire [39:0] bit_sel = bit_field >> {body_idx[2:0], 3'b000};

  // Register access
  wire [15:0] reg_rd_addr = addr_q + {8'h00, body_idx[8:1]};
  wire [15:0] reg_rd_data;
  wire [15:0] reg_wr_addr = addr_q + {9'h000, wr_i_q};
  wire [15:0] store_word;
  wire [W-1:0] store_rd_idx = mbt_pkg::OFS_WDATA + {1'b0, wr_i_q, 1'b0};
  wire wr_done = ({9'h000, wr_i_q} == qty_q - 16'h0001);
  wire reg_wr_en = in_write;

  wire relay_on = (qty_q == mbt_pkg::RELAY_ON_VAL);
  wire relay_off = (qty_q == mbt_pkg::RELAY_OFF_VAL);
  wire [2:0] relay_idx = addr_q[2:0] - mbt_pkg::RELAY_BASE[2:0];

  assign rx_ready = in_rx;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign tx_last = tx_last_q;
  assign relay_out = relay_q;

  mbt_frame_store #(
    .DEPTH(MAX_FRAME)
  ) u_store (
    .clk(clk),
    .wr_en(store_wr),
    .wr_idx(rx_cnt_q),
    .wr_data(rx_data),
    .rd_idx(store_rd_idx),
    .rd_word(store_word)
  );

  mbt_rtc_regs #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_regs (
    .clk(clk),
    .nrst(nrst),
    .wr_en(reg_wr_en),
    .wr_addr(reg_wr_addr),
    .wr_data(store_word),
    .rd_addr(reg_rd_addr),
    .rd_data(reg_rd_data)
  );

  // Response byte for ld_idx
  always_comb begin
    rsp_byte = 8'h00;
    case (ld_idx)
      mbt_pkg::OFS_TID: rsp_byte = hi_byte(tid_q);
      mbt_pkg::OFS_TID + 9'h001: rsp_byte = lo_byte(tid_q);
      mbt_pkg::OFS_PROTO: rsp_byte = hi_byte(mbt_pkg::PROTO_MODBUS);
      mbt_pkg::OFS_PROTO + 9'h001: rsp_byte = lo_byte(mbt_pkg::PROTO_MODBUS);
      mbt_pkg::OFS_LEN: rsp_byte = hi_byte(rsp_len);
      mbt_pkg::OFS_LEN + 9'h001: rsp_byte = lo_byte(rsp_len);
      mbt_pkg::OFS_UNIT: rsp_byte = unit_q;
      mbt_pkg::OFS_FC: rsp_byte = fc_q;
      default: begin
        if (is_wr_relay || is_wr_regs) begin
          // echo start and count or value
          if (ld_idx == mbt_pkg::OFS_ADDR) begin
            rsp_byte = hi_byte(addr_q);
          end else if (ld_idx == mbt_pkg::OFS_ADDR + 9'h001) begin
            rsp_byte = lo_byte(addr_q);
          end else if (ld_idx == mbt_pkg::OFS_QTY) begin
            rsp_byte = hi_byte(qty_q);
          end else begin
            rsp_byte = lo_byte(qty_q);
          end
        end else if (ld_idx == mbt_pkg::OFS_ADDR) begin
          rsp_byte = rsp_nbytes;
        end else if (is_rd_regs) begin
          rsp_byte = body_idx[0] ? lo_byte(reg_rd_data) : hi_byte(reg_rd_data);
        end else begin
          rsp_byte = bit_sel[7:0];
        end
      end
    endcase
  end

  // Frame sequencing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= mbt_pkg::ST_RX;
      wr_i_q <= 7'h00;
    end else begin
      case (state_q)
        mbt_pkg::ST_RX: begin
          if (rx_fire && rx_last) begin
            state_q <= mbt_pkg::ST_CHECK;
          end
        end
        mbt_pkg::ST_CHECK: begin
          wr_i_q <= 7'h00;
          if (!req_ok) begin
            state_q <= mbt_pkg::ST_RX;
          end else if (is_wr_regs) begin
            state_q <= mbt_pkg::ST_WRITE;
          end else begin
            state_q <= mbt_pkg::ST_SEND;
          end
        end
        mbt_pkg::ST_WRITE: begin
          wr_i_q <= wr_i_q + 7'h01;
          if (wr_done) begin
            state_q <= mbt_pkg::ST_SEND;
          end
        end
        mbt_pkg::ST_SEND: begin
          if (tx_ready && tx_last_q) begin
            state_q <= mbt_pkg::ST_RX;
          end
        end
        default: state_q <= mbt_pkg::ST_RX;
      endcase
    end
  end

  // Byte counter; bytes past the store set the overflow flag and the frame is dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_cnt_q <= 9'h000;
      rx_ovf_q <= 1'b0;
    end else if (in_check) begin
      rx_cnt_q <= 9'h000;
      rx_ovf_q <= 1'b0;
    end else if (rx_fire) begin
      if (rx_full) begin
        rx_ovf_q <= 1'b1;
      end else begin
        rx_cnt_q <= rx_cnt_q + 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tid_q <= 16'h0000;
      proto_q <= 16'h0000;
      len_q <= 16'h0000;
      unit_q <= 8'h00;
      fc_q <= 8'h00;
      addr_q <= 16'h0000;
      qty_q <= 16'h0000;
      bcnt_q <= 8'h00;
    end else if (rx_fire) begin
      case (rx_cnt_q)
        mbt_pkg::OFS_TID: tid_q[15:8] <= rx_data;
        mbt_pkg::OFS_TID + 9'h001: tid_q[7:0] <= rx_data;
        mbt_pkg::OFS_PROTO: proto_q[15:8] <= rx_data;
        mbt_pkg::OFS_PROTO + 9'h001: proto_q[7:0] <= rx_data;
        mbt_pkg::OFS_LEN: len_q[15:8] <= rx_data;
        mbt_pkg::OFS_LEN + 9'h001: len_q[7:0] <= rx_data;
        mbt_pkg::OFS_UNIT: unit_q <= rx_data;
        mbt_pkg::OFS_FC: fc_q <= rx_data;
        mbt_pkg::OFS_ADDR: addr_q[15:8] <= rx_data;
        mbt_pkg::OFS_ADDR + 9'h001: addr_q[7:0] <= rx_data;
        mbt_pkg::OFS_QTY: qty_q[15:8] <= rx_data;
        mbt_pkg::OFS_QTY + 9'h001: qty_q[7:0] <= rx_data;
        mbt_pkg::OFS_BCNT: bcnt_q <= rx_data;
        default: bcnt_q <= bcnt_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      relay_q <= mbt_pkg::RELAY_RESET;
    end else if (in_check && req_ok && is_wr_relay) begin
      if (relay_on) begin
        relay_q[relay_idx] <= 1'b1;
      end else if (relay_off) begin
        relay_q[relay_idx] <= 1'b0;
      end
    end
  end

  // Output register; the first byte loads on the same edge as a relay change
  wire start_send = (in_check && req_ok && !is_wr_regs) || (in_write && wr_done);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_idx_q <= 9'h000;
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_last_q <= 1'b0;
    end else if (start_send) begin
      tx_idx_q <= 9'h000;
      tx_data_q <= rsp_byte;
      tx_valid_q <= 1'b1;
      tx_last_q <= ld_last;
    end else if (in_send && tx_ready) begin
      tx_idx_q <= ld_idx;
      tx_data_q <= tx_last_q ? 8'h00 : rsp_byte;
      tx_valid_q <= !tx_last_q;
      tx_last_q <= !tx_last_q && ld_last;
    end
  end

endmodule : mbt_request_server

// file: verification/mbt_srv_monitor.sv
// Port-level protocol checker for the request server
`timescale 1ns/10ps
module mbt_srv_monitor (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset, low
  input wire logic rx_valid, // Req valid
  input wire logic [7:0] rx_data, // Req byte
  input wire logic rx_last, // Req end
  input wire logic rx_ready, // Req ready
  input wire logic tx_valid, // Rsp valid
  input wire logic [7:0] tx_data, // Rsp byte
  input wire logic tx_last, // Rsp end
  input wire logic tx_ready, // Rsp ready
  input wire logic [7:0] relay_out // Relays
);
  logic [8:0] rc_q, tc_q;
  logic [7:0] tid_q, unit_q, len_q;
  wire rx_take = rx_valid && rx_ready;
  wire tx_take = tx_valid && tx_ready;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) rc_q <= '0;
    else if (rx_take) rc_q <= rx_last ? 9'h000 : rc_q + 9'h001;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) tc_q <= '0;
    else if (tx_take) tc_q <= tx_last ? 9'h000 : tc_q + 9'h001;
  // Bytes of the request and reply that the reply must agree with
  always_ff @(posedge clk) begin
    if (rx_take && rc_q == 9'h000) tid_q <= rx_data;
    if (rx_take && rc_q == 9'h006) unit_q <= rx_data;
    if (tx_take && tc_q == 9'h005) len_q <= tx_data;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  AST_TID_ECHO: assert property (tx_valid && tc_q == 9'h000 |-> tx_data == tid_q)
    else $error("reply transaction id differs");
  AST_PROTO_ZERO: assert property (tx_valid && (tc_q == 9'h002 || tc_q == 9'h003) |-> tx_data == 8'h00)
    else $error("reply protocol id not zero");
  AST_UNIT_ECHO: assert property (tx_valid && tc_q == 9'h006 |-> tx_data == unit_q)
    else $error("reply unit id differs");
  AST_LEN_FIELD: assert property (tx_take && tx_last |-> len_q == tc_q[7:0] - 8'h05)
    else $error("reply length field wrong");
  AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("reply byte changed while stalled");
  AST_ONE_WAY: assert property (!(rx_ready && tx_valid))
    else $error("request taken during reply");
  AST_CHECK_GAP: assert property (rx_take && rx_last |=> !rx_ready && !tx_valid)
    else $error("no check cycle after request");
  AST_REPLY_BOUND: assert property (rx_take && rx_last |-> ##[2:130] (tx_valid || rx_ready))
    else $error("request neither answered nor dropped");
  AST_RELAY_EDGE: assert property (relay_out != $past(relay_out)
    |-> $rose(tx_valid) && $onehot(relay_out ^ $past(relay_out)))
    else $error("relay changed outside a single force");
endmodule : mbt_srv_monitor

bind mbt_request_server mbt_srv_monitor mbt_srv_monitor_inst (.clk(clk), .nrst(nrst), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_last(tx_last), .tx_ready(tx_ready), .relay_out(relay_out));

// file: verification/mbt_client_model.sv
// Client-side model: sends request frames, collects replies with random stalls
`timescale 1ns/10ps
module mbt_client_model (
  input wire logic clk, // Clock
  output logic rx_valid, // Req valid
  output logic [7:0] rx_data, // Req byte
  output logic rx_last, // Req end
  input wire logic rx_ready, // Req ready
  input wire logic tx_valid, // Rsp valid
  input wire logic [7:0] tx_data, // Rsp byte
  input wire logic tx_last, // Rsp end
  output logic tx_ready // Rsp ready
);
  logic [7:0] rsp[$];
  logic done = 1'b0;
  logic stuck = 1'b0;
  int stall = 0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h5a;
    rx_last = 1'b0;
  end
  // Stall percentage is set by the bench
  always @(negedge clk) tx_ready <= $urandom_range(99) >= stall;
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      rsp.push_back(tx_data);
      if (tx_last) done = 1'b1;
    end
  end
  // bytes leave in frame order, held until taken
  task automatic send(input logic [7:0] q[$]);
    int i;
    int n;
    rsp.delete();
    done = 1'b0;
    i = 0;
    for (n = 0; i < q.size() && n < 2000; n++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = q[i];
      rx_last = (i == q.size() - 1);
      @(posedge clk);
      if (rx_ready) i++;
    end
    if (i < q.size()) stuck = 1'b1;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data;
  endtask : send
endmodule : mbt_client_model

// file: verification/mbt_request_server_tb.sv
// Self-checking bench of the request server
`timescale 1ns/10ps
module mbt_request_server_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0] rx_data, tx_data, relay_out, unit;
  logic [7:0] relays = 8'h00;
  logic [37:0] din = '0;
  logic [39:0] w;
  logic [15:0] tid;
  logic [15:0] regs [6] = '{16'h07d0, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
  logic [7:0] q[$], e[$];
  int bi[4] = '{2, 5, 6, 7};
  logic [7:0] bv[4] = '{8'h01, 8'h07, 8'hf8, 8'h04};
  int num_errors = 0;
  int num_checks = 0;
  int s, r, v, k;
  always #50 clk = ~clk;
  // Tick kept far beyond the run so the clock-time registers hold still
  mbt_request_server #(.TICK_CYCLES(1000000)) mbt_request_server_inst (.clk(clk), .nrst(nrst),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .discrete_input_line(din), .relay_out(relay_out));
  mbt_client_model mbt_client_model_inst (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic req(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] b);
    q = {fc, a[15:8], a[7:0], b[15:8], b[7:0]};
  endtask : req
  // seven-byte header with length of what follows
  function automatic void wrap(inout logic [7:0] d[$]);
    logic [15:0] len;
    len = 16'(d.size() + 1);
    d = {tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0], unit, d};
  endfunction : wrap
  task automatic xfer(input int bad_i, input logic [7:0] bad_v);
    int n;
    tid = 16'($urandom);
    unit = 8'($urandom_range(247));
    wrap(q);
    wrap(e);
    if (bad_i >= 0) q[bad_i] = bad_v;
    if (bad_i >= 0) e = {};
    mbt_client_model_inst.send(q);
    for (n = 0; n < 400 && !mbt_client_model_inst.done; n++) @(negedge clk);
    if ((bad_i < 0 && n == 400) || mbt_client_model_inst.stuck) begin
      num_errors++;
      final_report();
    end
    check(16'(mbt_client_model_inst.rsp.size()), 16'(e.size()));
    for (n = 0; n < e.size(); n++) check(mbt_client_model_inst.rsp[n], e[n]);
    check(rx_ready, 1'b1);
    $display("test done: fc %h", q[7]);
  endtask : xfer
  initial begin
    void'($urandom(32'h1e1e02fe));
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    // clock-time registers, read at reset, then written and read back
    for (s = 0; s < 4; s++) begin
      if (s > 0) begin
        req(mbt_pkg::FC_WR_REGS, mbt_pkg::RTC_BASE, 16'h0006);
        e = q;
        q.push_back(8'h0c);
        for (k = 0; k < 6; k++) regs[k] = 16'($urandom);
        for (k = 0; k < 6; k++) q = {q, regs[k][15:8], regs[k][7:0]};
        xfer(-1, 8'h00);
      end
      r = (s == 0) ? 0 : $urandom_range(5);
      req(mbt_pkg::FC_RD_REGS, mbt_pkg::RTC_BASE + 16'(r), 16'(6 - r));
      e = {mbt_pkg::FC_RD_REGS, 8'(12 - 2 * r)};
      for (k = r; k < 6; k++) e = {e, regs[k][15:8], regs[k][7:0]};
      xfer(-1, 8'h00);
    end
    mbt_client_model_inst.stall = 50;
    // on, off, and a value that changes nothing
    for (s = 0; s < 9; s++) begin
      r = $urandom_range(7);
      v = (s % 3 == 0) ? 32'hff00 : (s % 3 == 1) ? 0 : $urandom_range(32'hfeff, 1);
      req(mbt_pkg::FC_WR_RELAY, 16'(r), 16'(v));
      e = q;
      if (s % 3 < 2) relays[r] = (s % 3 == 0);
      xfer(-1, 8'h00);
      check(relay_out, relays);
      r = $urandom_range(7);
      v = $urandom_range(8 - r, 1);
      req(mbt_pkg::FC_RD_RELAY, 16'(r), 16'(v));
      e = {mbt_pkg::FC_RD_RELAY, 8'h01, 8'((relays >> r) & ~(8'hff << v))};
      xfer(-1, 8'h00);
    end
    for (s = 0; s < 6; s++) begin
      din = {6'($urandom), 32'($urandom)};
      r = (s == 0) ? 0 : $urandom_range(37);
      v = (s == 0) ? 38 : $urandom_range(38 - r, 1);
      req(mbt_pkg::FC_RD_DIN, 16'(r), 16'(v));
      e = {mbt_pkg::FC_RD_DIN, 8'((v + 7) / 8)};
      w = 40'((din >> r) & ((38'h1 << v) - 38'h1));
      for (k = 0; k < v; k += 8) e.push_back(w[k+:8]);
      xfer(-1, 8'h00);
    end
    mbt_client_model_inst.stall = 0;
    // bad protocol, length, unit, and code are dropped
    for (s = 0; s < 4; s++) begin
      req(mbt_pkg::FC_RD_REGS, mbt_pkg::RTC_BASE, 16'h0001);
      e = {};
      xfer(bi[s], bv[s]);
    end
    final_report();
  end
endmodule : mbt_request_server_tb
